// File: rtl/vic_pkg.sv
// Behaviour
// - Ten causes, each branching to own vector.
// - Watchdog request is never masked.
// - Maskable cause needs master and own enable.
// - Highest vector address wins among pending.
// - Defer acceptance during skip, stack-load, decimal instructions.
// - Accept after deferring instruction if next doesn't defer.
// - Entry sequence lasts exactly five machine cycles.
// - Entry clears master enable, keeps source enables.
// - Entry lowers stack pointer by four.
// - Entry ends loading vector, clearing cause flag.
// - Return takes five cycles, restores full context.
// - Return raises stack pointer four, sets master.
// - Event sets its request bit immediately.
// - Software writing one sets a request bit.
// - Group 0 bit 3 from converter overflow.
// - Group 0 bit 2 from port 0 change.
// - Group 0 bit 1 from serial done.
// - Group 0 bit 0 from ports 2-4 change.
// - Group 1 bits from tick falling edges.
// - Group 2: watchdog bit 1, tenth-hertz bit 0.
// - Group 2 upper bits read one, ignore writes.
// - Enable bit ANDed with matching request bit.
// - Enable writes only while master enable is zero.
// - Software master enable allows nested acceptance.
// - Held request accepted once master enable returns.
package vic_pkg;

    // ******************************************
    // Register map
    // ******************************************
    localparam logic [6:0] ADDR_EN0 = 7'h30;
    localparam logic [6:0] ADDR_EN1 = 7'h31;
    localparam logic [6:0] ADDR_EN2 = 7'h32;
    localparam logic [6:0] ADDR_REQ2 = 7'h33;
    localparam logic [6:0] ADDR_REQ0 = 7'h34;
    localparam logic [6:0] ADDR_REQ1 = 7'h35;
    localparam logic [6:0] ADDR_MIEF = 7'h7c;

    localparam logic [3:0] RST_EN0 = 4'h0;
    localparam logic [3:0] RST_EN1 = 4'h0;
    localparam logic [3:0] RST_EN2 = 4'he;
    localparam logic [3:0] RST_REQ = 4'h0;
    localparam logic [3:0] RST_MIEF = 4'he;
    // Implemented bits; the rest read as one
    localparam logic [3:0] MASK_EN2 = 4'h1;
    localparam logic [3:0] MASK_REQ2 = 4'h3;
    localparam logic [3:0] MASK_MIEF = 4'h1;

    // ******************************************
    // Cause table, rank 0 lowest priority
    // ******************************************
    localparam int NUM_CAUSES = 10;
    localparam logic [3:0] WDT_RANK = 4'h9;
    localparam logic [1:0] WDT_GROUP = 2'h2;
    localparam logic [1:0] WDT_BIT = 2'h1;
    localparam logic [1:0] CAUSE_GROUP [NUM_CAUSES] =
        '{2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    localparam logic [1:0] CAUSE_BIT [NUM_CAUSES] =
        '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
    localparam logic [5:0] VECTOR_BASE = 6'h20;
    localparam logic [5:0] VECTOR_STEP = 6'h03;

    // ******************************************
    // Sequence timing in machine cycles
    // ******************************************
    localparam logic [2:0] SEQ_CYCLES = 3'h5;
    localparam logic [2:0] SEQ_LAST = 3'h4;
    localparam logic [2:0] SEQ_CTX_AT = 3'h0;
    localparam logic [2:0] SEQ_SP_AT = 3'h1;
    localparam logic [2:0] SP_STEP = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ENTRY,
        ST_RETURN
    } vic_seq_e;

    typedef struct packed {
        logic [6:0] addr;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } vic_bus_s;

    typedef struct packed {
        logic boundary;
        logic defer_next;
        logic rti_start;
    } vic_cpu_in_s;

    typedef struct packed {
        logic adc_overflow_req;
        logic [3:0] port0_level;
        logic serial_done_req;
        logic [11:0] port234_level;
        logic one_hz;
        logic sixteen_hz;
        logic thirtytwo_hz;
        logic twofiftysix_hz;
        logic tenth_hz;
        logic watchdog_overflow_req;
    } vic_event_s;

    typedef struct packed {
        logic busy;
        logic save_ctx;
        logic restore_ctx;
        logic sp_down;
        logic sp_up;
        logic pc_load;
        logic [5:0] vector;
    } vic_cpu_out_s;

endpackage

// File: rtl/vic_top.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module vic_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input vic_pkg::vic_bus_s bus,
    output logic [3:0] rdata,
    input vic_pkg::vic_event_s ev,
    input vic_pkg::vic_cpu_in_s cpu,
    output vic_pkg::vic_cpu_out_s cpu_out,
    output logic global_irq_enable
);
    import vic_pkg::*;

    // ******************************************
    // State
    // ******************************************
    logic [3:0] req_q [3];
    logic [3:0] req_d [3];
    logic [3:0] en_q [3];
    logic [3:0] en_d [3];
    logic mi_q, mi_d;
    logic [3:0] rdata_q, rdata_d;
    logic [3:0] port0_prev_q;
    logic [11:0] port234_prev_q;
    logic [4:0] tick_prev_q;
    logic primed_q;
    logic [3:0] evt [3];
    vic_seq_e state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [3:0] cause_q, cause_d;
    vic_cpu_out_s out_q, out_d;
    logic [NUM_CAUSES-1:0] gated;
    logic any_pending;
    logic [3:0] top_rank;
    logic accept;
    logic [4:0] tick_now;

    // ******************************************
    // Event detection
    // ******************************************
    assign tick_now = {ev.one_hz, ev.sixteen_hz, ev.thirtytwo_hz,
                       ev.twofiftysix_hz, ev.tenth_hz};

    // Edge detectors stay quiet for the first cycle so reset does not look like a change
    always_comb begin
        evt[0] = 4'h0;
        evt[1] = 4'h0;
        evt[2] = 4'h0;
        evt[0][3] = ev.adc_overflow_req;
        evt[0][2] = primed_q && (ev.port0_level != port0_prev_q);
        evt[0][1] = ev.serial_done_req;
        evt[0][0] = primed_q && (ev.port234_level != port234_prev_q);
        evt[1] = primed_q ? (tick_prev_q[4:1] & ~tick_now[4:1]) : 4'h0;
        evt[2][1] = ev.watchdog_overflow_req;
        evt[2][0] = primed_q && tick_prev_q[0] && !tick_now[0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port0_prev_q <= 4'h0;
            port234_prev_q <= 12'h000;
            tick_prev_q <= 5'h00;
            primed_q <= 1'b0;
        end else if (ce) begin
            port0_prev_q <= ev.port0_level;
            port234_prev_q <= ev.port234_level;
            tick_prev_q <= tick_now;
            primed_q <= 1'b1;
        end
    end

    // ******************************************
    // Gating and priority
    // ******************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CAUSES; gi++) begin : g_gate
            if (gi == WDT_RANK) begin : g_nmi
                assign gated[gi] = req_q[WDT_GROUP][WDT_BIT];
            end else begin : g_mask
                assign gated[gi] = mi_q && en_q[CAUSE_GROUP[gi]][CAUSE_BIT[gi]]
                                   && req_q[CAUSE_GROUP[gi]][CAUSE_BIT[gi]];
            end
        end
    endgenerate

    // Higher rank overrides, so the highest vector address wins
    always_comb begin
        top_rank = 4'h0;
        for (int i = 0; i < NUM_CAUSES; i++) begin
            if (gated[i]) begin
                top_rank = 4'(i);
            end
        end
    end

    assign any_pending = |gated;
    // Only at an instruction boundary whose next instruction does not defer
    assign accept = (state_q == ST_IDLE) && cpu.boundary && !cpu.defer_next
                    && any_pending;

    // ******************************************
    // Entry and return sequencer
    // ******************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cause_d = cause_q;
        case (state_q)
            ST_IDLE: begin
                cnt_d = 3'h0;
                if (accept) begin
                    state_d = ST_ENTRY;
                    cause_d = top_rank;
                end else if (cpu.rti_start) begin
                    state_d = ST_RETURN;
                end
            end
            ST_ENTRY, ST_RETURN: begin
                if (cnt_q == SEQ_LAST) begin
                    state_d = ST_IDLE;
                    cnt_d = 3'h0;
                end else begin
                    cnt_d = cnt_q + 3'h1;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 3'h0;
            end
        endcase
    end

    // Outputs are decoded from the next state so each stands registered
    always_comb begin
        out_d = '0;
        out_d.busy = (state_d != ST_IDLE);
        out_d.vector = out_q.vector;
        if (state_d == ST_ENTRY) begin
            out_d.save_ctx = (cnt_d == SEQ_CTX_AT);
            out_d.sp_down = (cnt_d == SEQ_SP_AT);
            if (cnt_d == SEQ_LAST) begin
                out_d.pc_load = 1'b1;
                out_d.vector = VECTOR_BASE + 6'(cause_d) * VECTOR_STEP;
            end
        end
        if (state_d == ST_RETURN) begin
            out_d.restore_ctx = (cnt_d == SEQ_CTX_AT);
            out_d.sp_up = (cnt_d == SEQ_SP_AT);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            cause_q <= 4'h0;
            out_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cause_q <= cause_d;
            out_q <= out_d;
        end
    end

    assign cpu_out = out_q;

    // ******************************************
    // Registers
    // ******************************************
    // Hardware set wins over both software writes and the acceptance clear
    always_comb begin
        logic clr_hit;
        logic [3:0] clr_mask;
        clr_hit = 1'b0;
        clr_mask = 4'h0;
        for (int g = 0; g < 3; g++) begin
            req_d[g] = req_q[g];
            en_d[g] = en_q[g];
        end
        mi_d = mi_q;
        if (bus.wr) begin
            if (bus.addr == ADDR_REQ0) begin
                req_d[0] = bus.wdata;
            end else if (bus.addr == ADDR_REQ1) begin
                req_d[1] = bus.wdata;
            end else if (bus.addr == ADDR_REQ2) begin
                req_d[2] = bus.wdata & MASK_REQ2;
            end else if (bus.addr == ADDR_MIEF) begin
                mi_d = bus.wdata[0];
            end else if (!mi_q && bus.addr == ADDR_EN0) begin
                en_d[0] = bus.wdata;
            end else if (!mi_q && bus.addr == ADDR_EN1) begin
                en_d[1] = bus.wdata;
            end else if (!mi_q && bus.addr == ADDR_EN2) begin
                en_d[2] = bus.wdata & MASK_EN2;
            end
        end
        if (out_d.pc_load) begin
            clr_hit = 1'b1;
            clr_mask[CAUSE_BIT[cause_d]] = 1'b1;
            req_d[CAUSE_GROUP[cause_d]] = req_d[CAUSE_GROUP[cause_d]] & ~clr_mask;
        end
        for (int g = 0; g < 3; g++) begin
            req_d[g] = req_d[g] | evt[g];
        end
        if (accept) begin
            mi_d = 1'b0;
        end else if (state_q == ST_RETURN && cnt_q == SEQ_LAST) begin
            mi_d = 1'b1;
        end
        if (clr_hit && rst) begin
            mi_d = 1'b0;
        end
    end

    always_comb begin
        rdata_d = 4'h0;
        if (bus.rd) begin
            if (bus.addr == ADDR_EN0) begin
                rdata_d = en_q[0];
            end else if (bus.addr == ADDR_EN1) begin
                rdata_d = en_q[1];
            end else if (bus.addr == ADDR_EN2) begin
                rdata_d = en_q[2] | ~MASK_EN2;
            end else if (bus.addr == ADDR_REQ2) begin
                rdata_d = req_q[2] | ~MASK_REQ2;
            end else if (bus.addr == ADDR_REQ0) begin
                rdata_d = req_q[0];
            end else if (bus.addr == ADDR_REQ1) begin
                rdata_d = req_q[1];
            end else if (bus.addr == ADDR_MIEF) begin
                rdata_d = {3'h7, mi_q} | ~MASK_MIEF;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_q[0] <= RST_REQ;
            req_q[1] <= RST_REQ;
            req_q[2] <= RST_REQ;
            en_q[0] <= RST_EN0;
            en_q[1] <= RST_EN1;
            en_q[2] <= RST_EN2 & MASK_EN2;
            mi_q <= RST_MIEF[0];
            rdata_q <= 4'h0;
        end else if (ce) begin
            req_q <= req_d;
            en_q <= en_d;
            mi_q <= mi_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign global_irq_enable = mi_q;

    // ******************************************
    // Assertions
    // ******************************************
    property p_entry_len;
        @(posedge clk) disable iff (rst || !ce)
        (accept && ce) |=> out_q.busy [*5] ##1 !out_q.busy;
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry not five cycles");

    property p_nmi;
        @(posedge clk) disable iff (rst || !ce)
        (state_q == ST_IDLE && cpu.boundary && !cpu.defer_next && req_q[2][1])
            |=> (cause_q == WDT_RANK && state_q == ST_ENTRY);
    endproperty
    a_nmi: assert property (p_nmi) else $error("watchdog not taken");

    property p_mask;
        @(posedge clk) disable iff (rst || !ce)
        (accept && top_rank != WDT_RANK) |-> mi_q;
    endproperty
    a_mask: assert property (p_mask) else $error("masked cause accepted");

    property p_mi_clear;
        @(posedge clk) disable iff (rst || !ce)
        accept |=> !mi_q [*4];
    endproperty
    a_mi_clear: assert property (p_mi_clear) else $error("master enable not cleared");

    property p_sp_down;
        @(posedge clk) disable iff (rst || !ce)
        accept |=> out_q.save_ctx ##1 out_q.sp_down ##1 !out_q.sp_down;
    endproperty
    a_sp_down: assert property (p_sp_down) else $error("stack step misplaced");

    property p_vector;
        @(posedge clk) disable iff (rst || !ce)
        accept |-> ##5 (out_q.pc_load
            && out_q.vector == VECTOR_BASE + 6'(cause_q) * VECTOR_STEP);
    endproperty
    a_vector: assert property (p_vector) else $error("vector load wrong");

    property p_return;
        @(posedge clk) disable iff (rst || !ce)
        (state_q == ST_IDLE && cpu.rti_start && !accept)
            |=> out_q.restore_ctx ##1 out_q.sp_up ##4 mi_q;
    endproperty
    a_return: assert property (p_return) else $error("return sequence wrong");

    property p_defer;
        @(posedge clk) disable iff (rst || !ce)
        (state_q == ST_IDLE && cpu.defer_next && !cpu.rti_start) |=> state_q == ST_IDLE;
    endproperty
    a_defer: assert property (p_defer) else $error("accepted while deferred");

    property p_reserved;
        @(posedge clk) disable iff (rst || !ce)
        (bus.rd && bus.addr == ADDR_REQ2) |=> rdata[3:2] == 2'h3;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not one");

    property p_en_lock;
        @(posedge clk) disable iff (rst || !ce)
        (bus.wr && bus.addr == ADDR_EN0 && mi_q) |=> en_q[0] == $past(en_q[0]);
    endproperty
    a_en_lock: assert property (p_en_lock) else $error("enable written while enabled");

    property p_priority;
        @(posedge clk) disable iff (rst || !ce)
        accept |-> (gated >> top_rank) == 10'h001;
    endproperty
    a_priority: assert property (p_priority) else $error("lower cause won");

    // Hardware set must survive both the software clear and the acceptance clear
    property p_event_set;
        @(posedge clk) disable iff (rst || !ce)
        (evt[0] != 4'h0 || evt[1] != 4'h0 || evt[2] != 4'h0)
            |=> ((req_q[0] & $past(evt[0])) == $past(evt[0]))
            && ((req_q[1] & $past(evt[1])) == $past(evt[1]))
            && ((req_q[2] & $past(evt[2])) == $past(evt[2]));
    endproperty
    a_event_set: assert property (p_event_set) else $error("event flag lost");

    property p_req_clear;
        @(posedge clk) disable iff (rst || !ce)
        (out_d.pc_load && !evt[CAUSE_GROUP[cause_d]][CAUSE_BIT[cause_d]])
            |=> !req_q[CAUSE_GROUP[cause_q]][CAUSE_BIT[cause_q]];
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request not cleared");

    property p_en_keep;
        @(posedge clk) disable iff (rst || !ce)
        (accept && !bus.wr) |=> (en_q[0] == $past(en_q[0])) && (en_q[1] == $past(en_q[1]))
            && (en_q[2] == $past(en_q[2]));
    endproperty
    a_en_keep: assert property (p_en_keep) else $error("enable changed on entry");

    property p_soft_set;
        @(posedge clk) disable iff (rst || !ce)
        (bus.wr && bus.addr == ADDR_REQ0 && !out_d.pc_load)
            |=> (req_q[0] & $past(bus.wdata)) == $past(bus.wdata);
    endproperty
    a_soft_set: assert property (p_soft_set) else $error("software set lost");

    property p_mi_write;
        @(posedge clk) disable iff (rst || !ce)
        (bus.wr && bus.addr == ADDR_MIEF && bus.wdata[0] && !accept) |=> mi_q;
    endproperty
    a_mi_write: assert property (p_mi_write) else $error("master enable write lost");

    property p_cov_nested;
        @(posedge clk) disable iff (rst || !ce)
        (state_q == ST_IDLE && mi_q && cpu.rti_start == 1'b0) ##1 accept;
    endproperty
    c_cov_nested: cover property (p_cov_nested);
    c_cov_wdt: cover property (@(posedge clk) disable iff (rst) accept && top_rank == WDT_RANK);
    c_cov_rti: cover property (@(posedge clk) disable iff (rst) state_q == ST_RETURN);
    c_cov_tenth: cover property (@(posedge clk) disable iff (rst) accept && top_rank == 4'h0);
    c_cov_defer: cover property (@(posedge clk) disable iff (rst)
        cpu.boundary && cpu.defer_next && any_pending);

endmodule // vic_top

// File: tb/vic_cpu_model.sv
`timescale 1ns/1ps
module vic_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire logic defer,
    input wire logic return_from_handler,
    input vic_pkg::vic_cpu_out_s cpu_out,
    output vic_pkg::vic_cpu_in_s cpu,
    output logic [7:0] sp,
    output logic [7:0] len,
    output logic [7:0] save_at,
    output logic [7:0] sp_at,
    output logic [7:0] load_at,
    output logic [7:0] vec
);
    import vic_pkg::*;
    logic [7:0] cnt_q;
    // Instruction ends are offered only while no sequence runs
    assign cpu.boundary = step & ~cpu_out.busy;
    assign cpu.defer_next = defer;
    assign cpu.rti_start = return_from_handler & ~cpu_out.busy;
    // Position of each strobe within the sequence, counted from its first busy cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            sp <= 8'h80;
        end else begin
            cnt_q <= cpu_out.busy ? cnt_q + 8'h01 : 8'h00;
            if (cpu_out.busy) len <= cnt_q + 8'h01;
            if (cpu_out.save_ctx | cpu_out.restore_ctx) save_at <= cnt_q;
            if (cpu_out.sp_down | cpu_out.sp_up) sp_at <= cnt_q;
            if (cpu_out.sp_down) sp <= sp - 8'h04;
            if (cpu_out.sp_up) sp <= sp + 8'h04;
            if (cpu_out.pc_load) begin
                load_at <= cnt_q;
                vec <= {2'h0, cpu_out.vector};
            end
        end
    end
endmodule // vic_cpu_model

// File: tb/tb_vectored_interrupt_controller.sv
`timescale 1ns/1ps
module tb_vectored_interrupt_controller;
    import vic_pkg::*;
    logic clk, rst, ce, step, defer, return_from_handler, global_irq_enable;
    logic [3:0] rdata, v;
    logic [7:0] sp, len, save_at, sp_at, load_at, vec, exp_vec;
    vic_bus_s bus;
    vic_event_s ev;
    vic_cpu_in_s cpu;
    vic_cpu_out_s cpu_out;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // Causes in falling priority: register address and bit of each
    localparam logic [6:0] c_addr [10] = '{7'h33, 7'h34, 7'h34, 7'h34, 7'h34,
        7'h35, 7'h35, 7'h35, 7'h35, 7'h33};
    localparam logic [3:0] c_mask [10] = '{4'h2, 4'h1, 4'h2, 4'h4, 4'h8,
        4'h1, 4'h2, 4'h4, 4'h8, 4'h1};

    vic_top uut (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .ev(ev), .cpu(cpu),
        .cpu_out(cpu_out), .global_irq_enable(global_irq_enable));
    vic_cpu_model core (.clk(clk), .rst(rst), .step(step), .defer(defer), .return_from_handler(return_from_handler),
        .cpu_out(cpu_out), .cpu(cpu), .sp(sp), .len(len), .save_at(save_at), .sp_at(sp_at),
        .load_at(load_at), .vec(vec));

    always #20 clk = ~clk;

    // ************************************
    // Bus and check tasks
    // ************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [3:0] d);
        @(posedge clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [3:0] d);
        @(posedge clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rc(input logic [6:0] a, input logic [3:0] e);
        logic [3:0] d;
        rd(a, d);
        chk({4'h0, d}, {4'h0, e});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (cpu_out.busy === 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    // Ends one instruction; e says whether an entry must follow
    task automatic bnd(input logic d, input logic e, input logic [7:0] vv);
        @(posedge clk);
        step <= 1'b1;
        defer <= d;
        @(posedge clk);
        step <= 1'b0;
        defer <= 1'b0;
        #1 chk({7'h0, cpu_out.busy}, {7'h0, e});
        wait_idle();
        if (e) begin
            chk(len, 8'h05);
            chk(save_at, 8'h00);
            chk(sp_at, 8'h01);
            chk(load_at, 8'h04);
            chk(vec, vv);
            chk({7'h0, global_irq_enable}, 8'h00);
        end
    endtask

    task automatic ret();
        @(posedge clk);
        return_from_handler <= 1'b1;
        @(posedge clk);
        return_from_handler <= 1'b0;
        #1 chk({7'h0, cpu_out.busy}, 8'h01);
        wait_idle();
        chk(len, 8'h05);
        chk(save_at, 8'h00);
        chk(sp_at, 8'h01);
        chk({7'h0, global_irq_enable}, 8'h01);
    endtask

    task automatic fire(input int i);
        @(posedge clk);
        case (i)
            0: ev.watchdog_overflow_req <= 1'b1;
            1: ev.port234_level[11] <= ~ev.port234_level[11];
            2: ev.serial_done_req <= 1'b1;
            3: ev.port0_level[3] <= ~ev.port0_level[3];
            4: ev.adc_overflow_req <= 1'b1;
            5: ev.twofiftysix_hz <= 1'b0;
            6: ev.thirtytwo_hz <= 1'b0;
            7: ev.sixteen_hz <= 1'b0;
            8: ev.one_hz <= 1'b0;
            default: ev.tenth_hz <= 1'b0;
        endcase
        // Ticks return high: a rising edge must leave the flag alone
        @(posedge clk);
        {ev.watchdog_overflow_req, ev.serial_done_req, ev.adc_overflow_req} <= 3'h0;
        {ev.one_hz, ev.sixteen_hz, ev.thirtytwo_hz, ev.twofiftysix_hz, ev.tenth_hz} <= 5'h1f;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            $display("CHECK FAILED at %0t: timeout", $time);
            summarize();
        end
    end

    // ************************************
    // Test sequence
    // ************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        bus = '0;
        ev = '0;
        {ev.one_hz, ev.sixteen_hz, ev.thirtytwo_hz, ev.twofiftysix_hz, ev.tenth_hz} = 5'h1f;
        {step, defer, return_from_handler} = 3'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rc(7'h30, 4'h0);
        rc(7'h31, 4'h0);
        rc(7'h32, 4'he);
        rc(7'h33, 4'hc);
        rc(7'h34, 4'h0);
        rc(7'h35, 4'h0);
        rc(7'h7c, 4'he);
        rc(7'h36, 4'h0);
        wr(7'h33, 4'hf);
        rc(7'h33, 4'hf);
        wr(7'h33, 4'h0);
        rc(7'h33, 4'hc);
        $display("test reset and map done");
        for (int i = 0; i < 10; i++) begin
            fire(i);
            rc(c_addr[i], c_mask[i] | (c_addr[i] == 7'h33 ? 4'hc : 4'h0));
            wr(c_addr[i], 4'h0);
            rc(c_addr[i], (c_addr[i] == 7'h33) ? 4'hc : 4'h0);
        end
        $display("test event sources done");
        wr(7'h30, 4'hf);
        wr(7'h31, 4'hf);
        wr(7'h32, 4'hf);
        rc(7'h32, 4'hf);
        wr(7'h34, 4'hf);
        wr(7'h35, 4'hf);
        wr(7'h33, 4'h3);
        wr(7'h7c, 4'h1);
        exp_vec = 8'h3b;
        for (int k = 0; k < 10; k++) begin
            bnd(1'b0, 1'b1, exp_vec);
            chk(sp, 8'h7c);
            rd(c_addr[k], v);
            chk({4'h0, v & c_mask[k]}, 8'h00);
            ret();
            chk(sp, 8'h80);
            exp_vec = exp_vec - 8'h03;
        end
        rc(7'h30, 4'hf);
        rc(7'h35, 4'h0);
        $display("test priority and sequences done");
        wr(7'h7c, 4'h0);
        wr(7'h30, 4'h0);
        wr(7'h31, 4'h0);
        wr(7'h32, 4'h0);
        wr(7'h33, 4'h2);
        wr(7'h34, 4'h8);
        bnd(1'b0, 1'b1, 8'h3b);
        ret();
        bnd(1'b0, 1'b0, 8'h00);
        wr(7'h30, 4'h8);
        rc(7'h30, 4'h0);
        wr(7'h7c, 4'h0);
        wr(7'h30, 4'h8);
        rc(7'h30, 4'h8);
        bnd(1'b0, 1'b0, 8'h00);
        wr(7'h7c, 4'h1);
        bnd(1'b1, 1'b0, 8'h00);
        bnd(1'b0, 1'b1, 8'h2f);
        wr(7'h30, 4'ha);
        wr(7'h34, 4'h2);
        bnd(1'b0, 1'b0, 8'h00);
        wr(7'h7c, 4'h1);
        bnd(1'b0, 1'b1, 8'h35);
        chk(sp, 8'h78);
        ret();
        ret();
        chk(sp, 8'h80);
        $display("test masking, deferral and nesting done");
        summarize();
    end
endmodule // tb_vectored_interrupt_controller
